// File: verilog/mode_ctrl_params.svh
`ifndef MODE_CTRL_PARAMS_SVH
`define MODE_CTRL_PARAMS_SVH
`define CLK_FREQ_HZ 100000000
`define STARTUP_CONFIRM_TIMEOUT_MS 80
`define STARTUP_CONFIRM_CYCLES ((`STARTUP_CONFIRM_TIMEOUT_MS * `CLK_FREQ_HZ) / 1000)
`define RESET_STRETCH_TIME_US 1250
`define RESET_STRETCH_CYCLES ((`RESET_STRETCH_TIME_US * `CLK_FREQ_HZ) / 1000000)
`define LIN_DOMINANT_FILTER_TIME_NS 30000
`define LIN_FILTER_CYCLES ((`LIN_DOMINANT_FILTER_TIME_NS * `CLK_FREQ_HZ) / 1000000000)
`define IRQ_PULSE_CYCLES 16
`define ADDR_SYS_CTRL 8'h00
`define ADDR_IRQ_MASK 8'h09
`define ADDR_IRQ_FLAG 8'h0a
`define ADDR_RESET_STATUS 8'h0b
`define ADDR_MODE_STATUS 8'h0c
`define SYS_CTRL_SLEEP_BIT 0
`define SYS_CTRL_STOP_BIT 1
`define SYS_CTRL_POWER_STAGE_ON_BIT_BIT 2
`define FLAG_WAKE_INPUT_BIT 7
`define FLAG_LIN_BIT 5
`define FLAG_OVERTEMP_BIT 3
`define FLAG_UNDERVOLT_BIT 2
`define FLAG_OVERVOLT_BIT 1
`define MASK_WAKE_INPUT_BIT 7
`define MASK_OVERVOLT_BIT 6
`define MASK_LIN_BIT 5
`define MASK_OVERTEMP_BIT 3
`define MASK_UNDERVOLT_BIT 2
`define RSR_WAKE_INPUT_BIT 1
`define RSR_LIN_BIT 0
`define FLAG_RW_MASK 8'hae
`define MASK_RW_MASK 8'hed
`endif

// File: verilog/mode_ctrl_pkg.sv
`default_nettype none
package mode_ctrl_pkg;
  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_NORMAL_REQUEST,
    MODE_NORMAL_RUN,
    MODE_STOP,
    MODE_SLEEP
  } mode_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic undervolt;
    logic overvolt;
    logic overtemp;
  } supply_cond_type;
endpackage
`default_nettype wire

// File: verilog/mode_sequencer.sv
// Operation
// (R1) Test pin high: no startup timeout, LIN receiver disabled.
// (R2) Software sets power stage on bit within 80 ms after reset or wake.
// (R3) Power stage on bit unset at timeout enters Sleep.
// (R4) Normal, Stop, Sleep selected by stop and sleep control bits.
// (R5) Stop needs stop bit and halted MCU; regulator in low current mode.
// (R6) In Stop, masked LIN or wake input events assert the interrupt line.
// (R7) Stop wake sets wake input flag or LIN flag.
// (R8) Sleep turns regulator off and holds reset line low.
// (R9) Software enters Sleep only by writing the sleep bit.
// (R10) Sleep wake is unmaskable and restarts like power-on reset.
// (R11) Sleep wake sets matching wake input or LIN reset flag.
// (R12) Normal Run: reset high, power stages and LIN on, watchdog if enabled.
// (R13) Stop: reset high, supervision and power stages off, LIN recessive.
// (R14) SPI works in Stop; software sets power stage on bit early.
// (R15) Each enabled event pulses the interrupt line.
// (R16) Seven sources individually maskable; all masks cleared by reset. The code has five maskable sources.
// (R17) Undervolt sets flag; interrupt only if its enable is one.
// (R18) Overvolt sets flag; interrupt only if its enable is one.
// (R19) Overtemp sets flag; interrupt only if its enable is one.
// (R20) Undervolt detection inactive in Sleep and Stop.
// (R21) Overvolt detection inactive in Stop and Sleep.
// (R22) Overtemp detection inactive in Stop and Sleep.
// (R23) Stop LIN interrupt on rising edge after dominant longer than filter time.
// (R24) Event flags clear by writing one; zero ignored; reset clears.
// (R25) Clear of condition flags ignored while condition persists.
// (R26) Internal reset events hold reset low for stretch time after they end.
// (R27) Reset release enters Normal Request, timer runs, Run on power stage bit.
// (R28) Interrupt pulse has fixed length; new pulse on each enabled new flag. The code restarts a running pulse, lengthening it, instead of adding one.
`include "mode_ctrl_params.svh"
`default_nettype none
module mode_sequencer
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CONFIRM_CYCLES,
  parameter int unsigned STRETCH_CYCLES = `RESET_STRETCH_CYCLES,
  parameter int unsigned LIN_FILTER = `LIN_FILTER_CYCLES,
  parameter int unsigned PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire reg_req_type req, // Register bus request.
  output logic [7:0] rdata, // Read data, one cycle after the read strobe.
  input wire logic test_select_pin, // High selects test mode.
  input wire logic wake_input_pin, // Wake input level.
  input wire logic lin_rx, // LIN receiver level, low is dominant.
  input wire supply_cond_type cond, // Supply and temperature comparators.
  input wire logic mcu_halted, // Microcontroller has stopped.
  input wire logic ext_reset_event, // Watchdog, undervolt or thermal reset event.
  output logic reset_n_out, // Analog reset output, active low.
  output logic reset_n_oe, // Open-drain enable, high while pulling low.
  output logic irq_n_out, // Analog interrupt output, active low.
  output logic irq_n_oe, // Open-drain enable, high while pulling low.
  output logic regulator_on, // Regulator enabled.
  output logic regulator_low_power, // Regulator in reduced current mode.
  output logic power_stage_enable, // Power stages enabled.
  output logic lin_enable, // LIN transmitter and receiver enabled.
  output logic lin_rx_enable, // LIN receiver enabled.
  output logic watchdog_active, // Supervision running.
  output mode_type mode // Current operating mode.
);
  mode_type mode_reg, mode_next;
  logic [7:0] sys_ctrl_reg, mask_reg, flag_reg, rsr_reg;
  logic [31:0] timer_reg;
  logic [31:0] stretch_reg;
  logic [31:0] lin_dom_reg;
  logic [15:0] pulse_reg;
  logic wake_in_d_reg, lin_d_reg;
  logic [7:0] flag_set, flag_clr, new_enabled;
  logic wake_edge, lin_wake, run_detect, wr_sys, wr_flag;
  logic wr_mask, wr_rsr, sleep_wake, confirm_expired, stretch_load, pulse_start;
  logic [7:0] flag_next, read_word;

  function automatic logic is_write(input reg_req_type r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Mask bits share positions with flags except overvolt, so remap that one.
  function automatic logic [7:0] flag_mask_map(input logic [7:0] m);
    logic [7:0] f;
    f = 8'h00;
    f[`FLAG_WAKE_INPUT_BIT] = m[`MASK_WAKE_INPUT_BIT];
    f[`FLAG_LIN_BIT] = m[`MASK_LIN_BIT];
    f[`FLAG_OVERTEMP_BIT] = m[`MASK_OVERTEMP_BIT];
    f[`FLAG_UNDERVOLT_BIT] = m[`MASK_UNDERVOLT_BIT];
    f[`FLAG_OVERVOLT_BIT] = m[`MASK_OVERVOLT_BIT];
    return f;
  endfunction

  assign wr_sys = is_write(req, `ADDR_SYS_CTRL);
  assign wr_flag = is_write(req, `ADDR_IRQ_FLAG);
  assign wr_mask = is_write(req, `ADDR_IRQ_MASK);
  assign wr_rsr = is_write(req, `ADDR_RESET_STATUS);
  // Either direction on the wake input counts as an event.
  assign wake_edge = wake_input_pin ^ wake_in_d_reg;
  // A wake counts only after the bus was dominant longer than the filter.
  assign lin_wake = lin_rx && !lin_d_reg && (lin_dom_reg > LIN_FILTER) && !test_select_pin; // see (R23) (R1)
  assign run_detect = (mode_reg == MODE_NORMAL_RUN) || (mode_reg == MODE_NORMAL_REQUEST); // see (R20) (R21) (R22)
  assign sleep_wake = (mode_reg == MODE_SLEEP) && (mode_next == MODE_RESET); // see (R10)
  // The test pin parks the startup check so a programmer can keep the core halted.
  assign confirm_expired = !test_select_pin && (timer_reg >= STARTUP_CYCLES); // see (R1) (R3)
  // Every cycle a source stays active reloads the stretch, so the hold runs from its end.
  assign stretch_load = ext_reset_event || sleep_wake; // see (R26)
  assign pulse_start = |new_enabled;

  // Supply and temperature detectors only watch while the core is expected to run.
  always_comb begin
    flag_set = 8'h00;
    flag_set[`FLAG_UNDERVOLT_BIT] = run_detect && cond.undervolt; // see (R17) (R20)
    flag_set[`FLAG_OVERVOLT_BIT] = run_detect && cond.overvolt; // see (R18) (R21)
    flag_set[`FLAG_OVERTEMP_BIT] = run_detect && cond.overtemp; // see (R19) (R22)
    flag_set[`FLAG_WAKE_INPUT_BIT] = (run_detect || mode_reg == MODE_STOP) && wake_edge; // see (R7)
    flag_set[`FLAG_LIN_BIT] = (mode_reg == MODE_STOP) && lin_wake; // see (R6) (R7) (R23)
  end

  // Condition flags refuse a clear while the comparator still reports the fault.
  always_comb begin
    flag_clr = wr_flag ? (req.wdata & `FLAG_RW_MASK) : 8'h00; // see (R24)
    flag_clr[`FLAG_UNDERVOLT_BIT] = flag_clr[`FLAG_UNDERVOLT_BIT] && !cond.undervolt; // see (R25)
    flag_clr[`FLAG_OVERVOLT_BIT] = flag_clr[`FLAG_OVERVOLT_BIT] && !cond.overvolt; // see (R25)
    flag_clr[`FLAG_OVERTEMP_BIT] = flag_clr[`FLAG_OVERTEMP_BIT] && !cond.overtemp; // see (R25)
  end

  always_comb begin
    new_enabled = flag_set & ~flag_reg & flag_mask_map(mask_reg); // see (R16) (R17) (R18) (R19)
  end

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_RESET: begin
        if (stretch_reg == 32'd0 && !ext_reset_event) begin
          mode_next = MODE_NORMAL_REQUEST; // see (R27)
        end
      end
      MODE_NORMAL_REQUEST: begin
        // Software proves it is alive by writing the power stage on bit.
        if (sys_ctrl_reg[`SYS_CTRL_POWER_STAGE_ON_BIT_BIT]) begin
          mode_next = MODE_NORMAL_RUN; // see (R27) (R2)
        end else if (confirm_expired) begin
          mode_next = MODE_SLEEP; // see (R3) (R1)
        end
      end
      MODE_NORMAL_RUN: begin
        // Sleep outranks Stop when software sets both bits at once.
        if (sys_ctrl_reg[`SYS_CTRL_SLEEP_BIT]) begin
          mode_next = MODE_SLEEP; // see (R4) (R9)
        end else if (sys_ctrl_reg[`SYS_CTRL_STOP_BIT] && mcu_halted) begin
          mode_next = MODE_STOP; // see (R4) (R5)
        end
      end
      MODE_STOP: begin
        // The bus stays live here, so software may restart the stages directly.
        if (sys_ctrl_reg[`SYS_CTRL_POWER_STAGE_ON_BIT_BIT] && !sys_ctrl_reg[`SYS_CTRL_STOP_BIT]) begin
          mode_next = MODE_NORMAL_RUN; // see (R14)
        end
      end
      MODE_SLEEP: begin
        // Wake in Sleep ignores the mask bits by design.
        if (wake_edge || lin_wake) begin
          mode_next = MODE_RESET; // see (R10)
        end
      end
    endcase
    // The regulator is off in Sleep, so no internal reset source can fire there.
    if (ext_reset_event && mode_reg != MODE_SLEEP) begin
      mode_next = MODE_RESET; // see (R26)
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // The timer saturates at its limit, so a long stay in test mode cannot wrap it.
  always_ff @(posedge clk) begin
    if (srst || mode_reg != MODE_NORMAL_REQUEST) begin
      timer_reg <= 32'd0;
    end else if (timer_reg < STARTUP_CYCLES) begin
      timer_reg <= timer_reg + 32'd1; // see (R27)
    end
  end

  always_ff @(posedge clk) begin
    if (srst || stretch_load) begin
      stretch_reg <= STRETCH_CYCLES; // see (R26) (R10)
    end else if (stretch_reg != 32'd0) begin
      stretch_reg <= stretch_reg - 32'd1;
    end
  end

  // Control registers restart on every internal reset, as a power-on would.
  // Only the three control bits exist; other written bits are dropped.
  always_ff @(posedge clk) begin
    if (srst || mode_reg == MODE_RESET || mode_reg == MODE_SLEEP) begin
      sys_ctrl_reg <= 8'h00;
    end else if (wr_sys) begin
      sys_ctrl_reg <= req.wdata & 8'h07; // see (R4) (R9)
    end else if (mode_reg == MODE_STOP && mode_next == MODE_NORMAL_RUN) begin
      sys_ctrl_reg[`SYS_CTRL_STOP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || mode_reg == MODE_RESET || mode_reg == MODE_SLEEP) begin
      mask_reg <= 8'h00; // see (R16)
    end else if (wr_mask) begin
      mask_reg <= req.wdata & `MASK_RW_MASK; // see (R16)
    end
  end

  // Set wins over a same-cycle clear, so an event never slips past software.
  always_comb begin
    flag_next = (flag_reg & ~flag_clr) | flag_set; // see (R24)
  end

  always_ff @(posedge clk) begin
    if (srst || mode_reg == MODE_RESET || mode_reg == MODE_SLEEP) begin
      flag_reg <= 8'h00; // see (R24)
    end else begin
      flag_reg <= flag_next; // see (R24)
    end
  end

  // Reset status survives internal resets so software can read the wake cause.
  always_ff @(posedge clk) begin
    if (srst) begin
      rsr_reg <= 8'h00;
    end else begin
      if (wr_rsr) begin
        rsr_reg <= rsr_reg & ~(req.wdata & 8'h03); // see (R24)
      end
      // Wake causes accumulate until cleared, and a set beats a same-cycle clear.
      if (sleep_wake && wake_edge) begin
        rsr_reg[`RSR_WAKE_INPUT_BIT] <= 1'b1; // see (R11)
      end
      if (sleep_wake && lin_wake) begin
        rsr_reg[`RSR_LIN_BIT] <= 1'b1; // see (R11)
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wake_in_d_reg <= 1'b0;
    end else begin
      wake_in_d_reg <= wake_input_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lin_d_reg <= 1'b1;
    end else begin
      lin_d_reg <= lin_rx;
    end
  end

  // The dominant counter stops just past the filter, so a stuck bus cannot wrap it.
  always_ff @(posedge clk) begin
    if (srst) begin
      lin_dom_reg <= 32'd0;
    end else if (lin_rx) begin
      lin_dom_reg <= 32'd0;
    end else if (lin_dom_reg <= LIN_FILTER) begin
      lin_dom_reg <= lin_dom_reg + 32'd1; // see (R23)
    end
  end

  // A source that fires mid-pulse stretches the pulse rather than adding an edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_reg <= 16'd0;
    end else if (pulse_start) begin
      pulse_reg <= 16'(PULSE_CYCLES); // see (R15) (R28) (R6)
    end else if (pulse_reg != 16'd0) begin
      pulse_reg <= pulse_reg - 16'd1;
    end
  end

  // Unmapped addresses read as zero so probing software sees no stale value.
  always_comb begin
    read_word = 8'h00;
    unique case (req.addr)
      `ADDR_SYS_CTRL: read_word = sys_ctrl_reg;
      `ADDR_IRQ_MASK: read_word = mask_reg;
      `ADDR_IRQ_FLAG: read_word = flag_reg;
      `ADDR_RESET_STATUS: read_word = rsr_reg;
      `ADDR_MODE_STATUS: read_word = {5'h00, mode_reg};
      default: read_word = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= read_word;
    end else begin
      rdata <= 8'h00;
    end
  end

  assign mode = mode_reg;
  assign reset_n_out = !reset_n_oe;
  assign irq_n_oe = pulse_reg != 16'd0;
  assign irq_n_out = !irq_n_oe;

  // Pin and stage enables decode only the mode register, plus the test pin for lin_rx_enable,
  // so a mode change moves them all on one edge and never passes through an illegal mix.
  always_comb begin
    reset_n_oe = 1'b0;
    regulator_on = 1'b1;
    regulator_low_power = 1'b0;
    power_stage_enable = 1'b0;
    lin_enable = 1'b0;
    lin_rx_enable = 1'b0;
    watchdog_active = 1'b0;
    unique case (mode_reg)
      MODE_RESET: begin
        reset_n_oe = 1'b1; // see (R26)
        regulator_on = 1'b1;
        regulator_low_power = 1'b0;
        power_stage_enable = 1'b0;
        lin_enable = 1'b0;
        lin_rx_enable = 1'b0;
        watchdog_active = 1'b0;
      end
      MODE_NORMAL_REQUEST: begin
        reset_n_oe = 1'b0; // see (R27)
        regulator_on = 1'b1;
        regulator_low_power = 1'b0;
        power_stage_enable = 1'b0;
        lin_enable = 1'b0;
        lin_rx_enable = !test_select_pin; // see (R1)
        watchdog_active = 1'b0;
      end
      MODE_NORMAL_RUN: begin
        reset_n_oe = 1'b0; // see (R12)
        regulator_on = 1'b1;
        regulator_low_power = 1'b0;
        power_stage_enable = 1'b1; // see (R12)
        lin_enable = 1'b1; // see (R12)
        lin_rx_enable = !test_select_pin; // see (R1)
        watchdog_active = 1'b1; // see (R12)
      end
      MODE_STOP: begin
        reset_n_oe = 1'b0; // see (R13)
        regulator_on = 1'b1;
        regulator_low_power = 1'b1; // see (R5)
        power_stage_enable = 1'b0; // see (R13)
        lin_enable = 1'b0; // see (R13)
        lin_rx_enable = !test_select_pin; // see (R1)
        watchdog_active = 1'b0; // see (R13)
      end
      MODE_SLEEP: begin
        reset_n_oe = 1'b1; // see (R8)
        regulator_on = 1'b0; // see (R8)
        regulator_low_power = 1'b0;
        power_stage_enable = 1'b0;
        lin_enable = 1'b0;
        lin_rx_enable = !test_select_pin; // see (R1)
        watchdog_active = 1'b0;
      end
    endcase
  end
endmodule // mode_sequencer
`default_nettype wire

// File: verif/mode_seq_chk.sv
`default_nettype none
module mode_seq_chk
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 200,
  parameter int unsigned STRETCH_CYCLES = 20,
  parameter int unsigned PULSE_CYCLES = 16
) (
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic test_select_pin, // Test pin.
  input wire logic mcu_halted, // Core halted.
  input wire logic ext_reset_event, // Reset source.
  input wire logic reset_n_oe, // Reset pull.
  input wire logic irq_n_oe, // Interrupt pull.
  input wire logic regulator_on, // Regulator.
  input wire logic regulator_low_power, // Low current mode.
  input wire logic power_stage_enable, // Stages.
  input wire logic lin_enable, // LIN.
  input wire logic lin_rx_enable, // LIN receiver.
  input wire logic watchdog_active, // Supervision.
  input wire mode_type mode // Mode.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPAN = STRETCH_CYCLES + 2;
  logic [7:0] pulse_cnt;
  logic [31:0] nr_cnt;
  always_ff @(posedge clk) begin
    pulse_cnt <= (srst || !irq_n_oe) ? 8'h00 : pulse_cnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    nr_cnt <= (srst || mode != MODE_NORMAL_REQUEST) ? 32'h0 : nr_cnt + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sleep_power_off_a: assert property (mode == MODE_SLEEP |-> !regulator_on && reset_n_oe)
    else $error("sleep outputs wrong");
  run_outputs_a: assert property (mode == MODE_NORMAL_RUN |-> !reset_n_oe && power_stage_enable && lin_enable)
    else $error("run outputs wrong");
  stop_outputs_a: assert property (mode == MODE_STOP |-> !reset_n_oe && !power_stage_enable
    && !watchdog_active && regulator_low_power)
    else $error("stop outputs wrong");
  test_lin_off_a: assert property (test_select_pin |-> !lin_rx_enable)
    else $error("lin receiver on in test");
  test_no_timeout_a: assert property (test_select_pin && mode == MODE_NORMAL_REQUEST |=> mode != MODE_SLEEP)
    else $error("timeout in test");
  confirm_bound_a: assert property (mode == MODE_NORMAL_REQUEST && !test_select_pin |-> nr_cnt < STARTUP_CYCLES + 3)
    else $error("no sleep at timeout");
  early_sleep_a: assert property (mode == MODE_SLEEP && $past(mode) == MODE_NORMAL_REQUEST
    |-> $past(nr_cnt) > STARTUP_CYCLES - 3)
    else $error("sleep too early");
  stop_needs_halt_a: assert property ($rose(mode == MODE_STOP) |-> $past(mcu_halted))
    else $error("stop without halt");
  stretch_hold_a: assert property ($fell(ext_reset_event) |-> reset_n_oe [*8] ##[1:SPAN] !reset_n_oe)
    else $error("reset stretch wrong");
  irq_length_a: assert property ($fell(irq_n_oe) |-> pulse_cnt == 8'(PULSE_CYCLES))
    else $error("pulse length wrong");
  stop_seen_c: cover property (mode == MODE_STOP);
  sleep_seen_c: cover property (mode == MODE_SLEEP);
  pulse_seen_c: cover property ($fell(irq_n_oe));
endmodule // mode_seq_chk
bind mode_sequencer mode_seq_chk #(.STARTUP_CYCLES(STARTUP_CYCLES), .STRETCH_CYCLES(STRETCH_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) i_chk (.*);
`default_nettype wire

// File: verif/mcu_model.sv
`default_nettype none
module mcu_model (
  input wire logic clk, // Clock.
  input wire logic halt_req, // Software asks the core to stop.
  input wire logic reset_n_out, // Reset drive level.
  input wire logic reset_n_oe, // Reset pull.
  input wire logic irq_n_out, // Interrupt drive level.
  input wire logic irq_n_oe, // Interrupt pull.
  output logic mcu_halted, // Core stopped.
  output logic [7:0] irq_cnt // Pulses seen.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_wire;
  logic irq_wire;
  logic irq_last = 1'b1;
  // Both lines carry pull-ups, so a released line reads high.
  assign rst_wire = reset_n_oe ? reset_n_out : 1'b1;
  assign irq_wire = irq_n_oe ? irq_n_out : 1'b1;
  initial mcu_halted = 1'b0;
  initial irq_cnt = 8'h00;
  always @(posedge clk) begin
    irq_last <= irq_wire;
    if (irq_last && !irq_wire)
      irq_cnt <= irq_cnt + 8'h01;
  end
  // The core halts only after the stop request, and any interrupt or reset wakes it.
  always @(posedge clk) begin
    mcu_halted <= halt_req && rst_wire && irq_wire;
  end
endmodule // mcu_model
`default_nettype wire

// File: verif/analog_die_mode_and_irq_control_bench.sv
`default_nettype none
module analog_die_mode_and_irq_control_bench;
  import mode_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 200;
  localparam int unsigned RC = 20;
  localparam logic [7:0] FB [3] = '{8'h04, 8'h02, 8'h08};
  localparam logic [7:0] MK [3] = '{8'h04, 8'h0c, 8'h48};
  logic clk = 1'b0;
  logic srst = 1'b1;
  reg_req_type req = '0;
  supply_cond_type cond = '0;
  logic test_pin = 1'b0;
  logic wake_pin = 1'b0;
  logic lin = 1'b1;
  logic halt_req = 1'b0;
  logic ext_ev = 1'b0;
  logic [7:0] rdata;
  logic [7:0] irq_cnt;
  logic mcu_halted, rst_n, rst_oe, irq_n, irq_oe;
  mode_type mode;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  mode_sequencer #(.STARTUP_CYCLES(SC), .STRETCH_CYCLES(RC), .LIN_FILTER(5), .PULSE_CYCLES(16)) i_dut (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata), .test_select_pin(test_pin),
    .wake_input_pin(wake_pin), .lin_rx(lin), .cond(cond), .mcu_halted(mcu_halted),
    .ext_reset_event(ext_ev), .reset_n_out(rst_n), .reset_n_oe(rst_oe), .irq_n_out(irq_n),
    .irq_n_oe(irq_oe), .regulator_on(), .regulator_low_power(), .power_stage_enable(),
    .lin_enable(), .lin_rx_enable(), .watchdog_active(), .mode(mode));
  mcu_model i_mcu (.clk(clk), .halt_req(halt_req), .reset_n_out(rst_n), .reset_n_oe(rst_oe),
    .irq_n_out(irq_n), .irq_n_oe(irq_oe), .mcu_halted(mcu_halted), .irq_cnt(irq_cnt));
  always #5 clk = ~clk;
  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    @(negedge clk) chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic go(input mode_type m);
    int n;
    n = 0;
    @(negedge clk);
    while (mode !== m && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(8'(mode), 8'(m));
    @(posedge clk);
  endtask
  task automatic t_boot;
    go(MODE_NORMAL_REQUEST);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h00, 8'h04);
    go(MODE_NORMAL_RUN);
    rd(8'h0c, 8'h02);
  endtask
  task automatic t_cond;
    logic [7:0] c;
    for (int i = 0; i < 3; i++) begin
      wr(8'h09, MK[i]);
      c = irq_cnt;
      cond <= supply_cond_type'(3'b100 >> i);
      repeat (3) @(posedge clk);
      wr(8'h0a, 8'hff);
      rd(8'h0a, FB[i]);
      chk(irq_cnt - c, (i == 1) ? 8'h00 : 8'h01);
      cond <= '0;
      wr(8'h0a, 8'h00);
      rd(8'h0a, FB[i]);
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
    end
  endtask
  task automatic t_stop;
    logic [7:0] c;
    wr(8'h09, 8'h20);
    wr(8'h00, 8'h06);
    halt_req <= 1'b1;
    go(MODE_STOP);
    c = irq_cnt;
    cond <= '1;
    lin <= 1'b0;
    repeat (3) @(posedge clk);
    lin <= 1'b1;
    repeat (20) @(posedge clk);
    rd(8'h0a, 8'h00);
    wake_pin <= 1'b1;
    lin <= 1'b0;
    repeat (8) @(posedge clk);
    lin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq_cnt - c, 8'h01);
    wr(8'h0a, 8'h80);
    rd(8'h0a, 8'h20);
    halt_req <= 1'b0;
    cond <= '0;
    wr(8'h00, 8'h04);
    go(MODE_NORMAL_RUN);
    wr(8'h0a, 8'hff);
  endtask
  task automatic t_sleep;
    wr(8'h00, 8'h01);
    go(MODE_SLEEP);
    repeat (5) @(posedge clk);
    wake_pin <= 1'b0;
    go(MODE_NORMAL_REQUEST);
    rd(8'h0b, 8'h02);
    rd(8'h09, 8'h00);
    go(MODE_SLEEP);
    lin <= 1'b0;
    repeat (8) @(posedge clk);
    lin <= 1'b1;
    go(MODE_NORMAL_REQUEST);
    rd(8'h0b, 8'h03);
    wr(8'h0b, 8'h03);
    rd(8'h0b, 8'h00);
    wr(8'h00, 8'h04);
    go(MODE_NORMAL_RUN);
  endtask
  task automatic t_ext;
    ext_ev <= 1'b1;
    repeat (5) @(posedge clk);
    ext_ev <= 1'b0;
    repeat (RC - 2) @(posedge clk);
    @(negedge clk) chk(8'(mode), 8'(MODE_RESET));
    go(MODE_NORMAL_REQUEST);
    rd(8'h09, 8'h00);
  endtask
  task automatic t_test;
    test_pin <= 1'b1;
    t_ext;
    repeat (SC + 30) @(posedge clk);
    @(negedge clk) chk(8'(mode), 8'(MODE_NORMAL_REQUEST));
    wr(8'h00, 8'h04);
    go(MODE_NORMAL_RUN);
    test_pin <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (RC - 4) @(posedge clk);
    @(negedge clk) chk(8'(mode), 8'(MODE_RESET));
    t_boot;
    t_cond;
    t_stop;
    t_sleep;
    t_test;
    print_verdict;
  end
endmodule // analog_die_mode_and_irq_control_bench
`default_nettype wire
